//--- logic/fiap_seq.sv
// Flash IAP program sequencer top with APB register slave and page buffer
//
// Local design decisions: the APB register port and the address map.
`include "fiap_map.svh"
module fiap_seq #(
  parameter int unsigned PAGE_WORDS = 64,
  parameter int unsigned PROG_CYC = `FIAP_PROG_CYC,
  parameter int unsigned UNLOCK_CYC = `FIAP_UNLOCK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_cpu_stall,
  output logic o_fl_erase,
  output logic o_fl_prog,
  output logic o_fl_read,
  output logic [13:0] o_fl_addr,
  output logic [15:0] o_fl_wdata,
  output logic [5:0] o_fl_widx,
  input wire logic [15:0] i_fl_rdata
);
  import fiap_pkg::*;
  localparam int unsigned TW = 20;

  logic [7:0] ctrl_reg;
  logic clr_req_reg;
  logic [13:0] addr_reg;
  logic [7:0] d0l_reg, d0h_reg;
  logic [7:0] k1l_reg, k1h_reg, k2l_reg, k2h_reg, k3l_reg, k3h_reg;
  logic [5:0] ptr_reg;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [5:0] idx_reg;
  logic tail_reg;
  fiap_state_t st_reg;
  logic unl_active, unl_grant, tmr_done, tmr_load;
  logic [TW-1:0] tmr_cnt;

  // APB decode: writes act only at the edge where ready is seen, one-cycle answer
  wire acc = i_psel && i_penable && o_pready;
  wire wr = acc && i_pwrite;
  // Register hits by byte offset; every register takes one aligned word
  wire hit_ctrl = i_paddr == `FIAP_OFF_CTRL;
  wire hit_bclr = i_paddr == `FIAP_OFF_BCLR;
  wire hit_al = i_paddr == `FIAP_OFF_ADDRL;
  wire hit_ah = i_paddr == `FIAP_OFF_ADDRH;
  wire hit_d0l = i_paddr == `FIAP_OFF_D0L;
  wire hit_d0h = i_paddr == `FIAP_OFF_D0H;
  wire hit_k1l = i_paddr == `FIAP_OFF_K1L;
  wire hit_k1h = i_paddr == `FIAP_OFF_K1H;
  wire hit_k2l = i_paddr == `FIAP_OFF_K2L;
  wire hit_k2h = i_paddr == `FIAP_OFF_K2H;
  wire hit_k3l = i_paddr == `FIAP_OFF_K3L;
  wire hit_k3h = i_paddr == `FIAP_OFF_K3H;
  wire hit_stat = i_paddr == `FIAP_OFF_STAT;
  // Unmapped offsets answer with an error and read as zero
  wire mapped = hit_ctrl | hit_bclr | hit_al | hit_ah | hit_d0l | hit_d0h | hit_k1l | hit_k1h
                | hit_k2l | hit_k2h | hit_k3l | hit_k3h | hit_stat;
  // Writable registers are at most byte wide; upper write data bits are ignored
  wire [7:0] wb = i_pwdata[7:0];

  // Control field views
  wire [2:0] mode = ctrl_reg[`FIAP_B_MODE_HI:`FIAP_B_MODE_LO];
  wire en = ctrl_reg[`FIAP_B_EN];
  wire idle = st_reg == FIAP_ST_IDLE;
  wire ctrl_wr = wr && hit_ctrl && idle;
  wire trig_set = ctrl_wr && wb[`FIAP_B_TRIG] && (mode == FIAP_MODE_UNLOCK);
  wire wt_set = ctrl_wr && wb[`FIAP_B_WT] && !ctrl_reg[`FIAP_B_WT];
  wire rd_set = ctrl_wr && wb[`FIAP_B_RD] && !ctrl_reg[`FIAP_B_RD];
  // Operation starts: erase/write need the enabled flag, read does not
  wire go_erase = wt_set && en && (wb[6:4] == FIAP_MODE_ERASE);
  wire go_prog = wt_set && en && (wb[6:4] == FIAP_MODE_WRITE);
  wire go_read = rd_set && wb[`FIAP_B_RDEN] && (wb[6:4] == FIAP_MODE_READ);
  // Key is only compared while the window is open, latched at expiry
  wire key_ok = (k1l_reg == `FIAP_KEY1L) && (k2l_reg == `FIAP_KEY2L)
                && (k3l_reg == `FIAP_KEY3L) && (k1h_reg == `FIAP_KEY1H)
                && (k2h_reg == `FIAP_KEY2H) && (k3h_reg == `FIAP_KEY3H);
  wire last_prog = idx_reg == 6'(PAGE_WORDS - 1);

  fiap_unlock #(.WINDOW_CYC(UNLOCK_CYC)) i_fiap_unlock (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(trig_set),
    .i_key_ok(key_ok),
    .o_active(unl_active),
    .o_granted(unl_grant)
  );

  // Timer load value: long for erase/program, short for read
  assign tmr_load = go_erase | go_prog | go_read;
  assign tmr_cnt = go_read ? TW'(`FIAP_RD_CYC) : TW'(PROG_CYC);

  fiap_timer #(.W(TW)) i_fiap_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(tmr_load),
    .i_count(tmr_cnt),
    .o_done(tmr_done)
  );

  // Control register: enable flag only set by unlock hardware
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_reg <= `FIAP_CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg[6:4] <= wb[6:4];
        ctrl_reg[`FIAP_B_RDEN] <= wb[`FIAP_B_RDEN];
        ctrl_reg[`FIAP_B_EN] <= en & wb[`FIAP_B_EN];
        ctrl_reg[`FIAP_B_WT] <= go_erase | go_prog;
        ctrl_reg[`FIAP_B_RD] <= go_read;
      end
      ctrl_reg[`FIAP_B_TRIG] <= unl_active | trig_set;
      // Grant is the only way the enabled flag is ever set
      if (unl_grant) begin
        ctrl_reg[`FIAP_B_EN] <= 1'b1;
      end
      // Hardware completion wins; ctrl writes are refused while busy anyway
      if (tmr_done) begin
        ctrl_reg[`FIAP_B_WT] <= 1'b0;
        ctrl_reg[`FIAP_B_RD] <= 1'b0;
      end
    end
  end

  // Address, data and key registers; address low write reloads pointer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      addr_reg <= 14'h0000;
      ptr_reg <= 6'h00;
      d0l_reg <= 8'h00;
      d0h_reg <= 8'h00;
      {k1l_reg, k1h_reg, k2l_reg, k2h_reg, k3l_reg, k3h_reg} <= 48'h0000_0000_0000;
    end else begin
      if (wr && hit_al) begin
        addr_reg[7:0] <= wb;
        ptr_reg <= wb[5:0];
      end
      if (wr && hit_ah) begin
        addr_reg[13:8] <= wb[5:0];
      end
      if (wr && hit_d0l) begin
        d0l_reg <= wb;
      end
      if (wr && hit_d0h) begin
        d0h_reg <= wb;
        if (ptr_reg != 6'(PAGE_WORDS - 1)) begin
          ptr_reg <= ptr_reg + 6'h01;
        end
      end
      // Key bytes stay after the window; a retrigger compares whatever is left
      if (wr && hit_k1l) begin
        k1l_reg <= wb;
      end
      if (wr && hit_k1h) begin
        k1h_reg <= wb;
      end
      if (wr && hit_k2l) begin
        k2l_reg <= wb;
      end
      if (wr && hit_k2h) begin
        k2h_reg <= wb;
      end
      if (wr && hit_k3l) begin
        k3l_reg <= wb;
      end
      if (wr && hit_k3h) begin
        k3h_reg <= wb;
      end
      if (tmr_done && st_reg == FIAP_ST_READ) begin
        {d0h_reg, d0l_reg} <= i_fl_rdata;
      end
    end
  end

  // Page buffer: word stored on high-byte write, cleared on request
  always_ff @(posedge i_clk) begin
    if (wr && hit_d0h) begin
      buf_mem[ptr_reg] <= {wb, d0l_reg};
    end else if (clr_req_reg) begin
      buf_mem[idx_reg] <= 16'h0000;
    end
  end

  // Buffer clear walks the page one word per cycle, then drops the bit
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      clr_req_reg <= 1'b0;
    end else if (wr && hit_bclr && wb[0] && idle) begin
      clr_req_reg <= 1'b1;
    end else if (clr_req_reg && idx_reg == 6'(PAGE_WORDS - 1)) begin
      clr_req_reg <= 1'b0;
    end
  end

  // Operation state machine; whole page erased or programmed
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_reg <= FIAP_ST_IDLE;
      idx_reg <= 6'h00;
      tail_reg <= 1'b0;
      o_fl_erase <= 1'b0;
      o_fl_prog <= 1'b0;
      o_fl_read <= 1'b0;
      o_fl_addr <= 14'h0000;
      o_fl_wdata <= 16'h0000;
      o_fl_widx <= 6'h00;
      o_cpu_stall <= 1'b0;
    end else begin
      o_fl_erase <= 1'b0;
      o_fl_prog <= 1'b0;
      o_fl_read <= 1'b0;
      unique case (st_reg)
        FIAP_ST_IDLE: begin
          // Clear walk shares idx_reg with the program stream
          tail_reg <= 1'b0;
          if (clr_req_reg) begin
            idx_reg <= idx_reg + 6'h01;
          end else begin
            idx_reg <= 6'h00;
          end
          if (go_erase) begin
            st_reg <= FIAP_ST_ERASE;
            o_fl_erase <= 1'b1;
            o_fl_addr <= {addr_reg[13:6], 6'h00};
            o_cpu_stall <= 1'b1;
          end else if (go_prog) begin
            st_reg <= FIAP_ST_PROG;
            o_cpu_stall <= 1'b1;
          end else if (go_read) begin
            st_reg <= FIAP_ST_READ;
            o_fl_read <= 1'b1;
            o_fl_addr <= addr_reg;
            o_cpu_stall <= 1'b1;
          end
        end
        FIAP_ST_PROG: begin
          // Stream every buffer word once; the last word is flagged so it is not resent
          // The stream runs off the timer, so PROG_CYC below PAGE_WORDS - 1 cuts it short
          if (!tail_reg) begin
            o_fl_prog <= 1'b1;
            o_fl_addr <= {addr_reg[13:6], idx_reg};
            o_fl_widx <= idx_reg;
            o_fl_wdata <= buf_mem[idx_reg];
          end
          if (last_prog) begin
            tail_reg <= 1'b1;
          end else begin
            idx_reg <= idx_reg + 6'h01;
          end
          if (tmr_done) begin
            st_reg <= FIAP_ST_IDLE;
            o_cpu_stall <= 1'b0;
            idx_reg <= 6'h00;
          end
        end
        FIAP_ST_ERASE, FIAP_ST_READ: begin
          if (tmr_done) begin
            st_reg <= FIAP_ST_IDLE;
            o_cpu_stall <= 1'b0;
          end
        end
        default: begin
          st_reg <= FIAP_ST_IDLE;
        end
      endcase
    end
  end

  // Read mux, registered so outputs come from flip-flops
  wire [31:0] rmux = hit_ctrl ? {24'h00_0000, ctrl_reg}
                   : hit_bclr ? {31'h0000_0000, clr_req_reg}
                   : hit_al ? {24'h00_0000, addr_reg[7:0]}
                   : hit_ah ? {26'h000_0000, addr_reg[13:8]}
                   : hit_d0l ? {24'h00_0000, d0l_reg}
                   : hit_d0h ? {24'h00_0000, d0h_reg}
                   : hit_k1l ? {24'h00_0000, k1l_reg}
                   : hit_k1h ? {24'h00_0000, k1h_reg}
                   : hit_k2l ? {24'h00_0000, k2l_reg}
                   : hit_k2h ? {24'h00_0000, k2h_reg}
                   : hit_k3l ? {24'h00_0000, k3l_reg}
                   : hit_k3h ? {24'h00_0000, k3h_reg}
                   : hit_stat ? {22'h00_0000, ptr_reg, st_reg}
                   : 32'h0000_0000;

  // Ready one cycle into access phase, error on unmapped address
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !mapped;
      o_prdata <= (i_psel && !i_penable) ? rmux : 32'h0000_0000;
    end
  end
endmodule

//--- logic/fiap_map.svh
// Register offsets, field positions, reset values and timing counts of the flash IAP sequencer
`ifndef FIAP_MAP_SVH
`define FIAP_MAP_SVH
`define FIAP_OFF_CTRL 12'h000
`define FIAP_OFF_BCLR 12'h004
`define FIAP_OFF_ADDRL 12'h008
`define FIAP_OFF_ADDRH 12'h00C
`define FIAP_OFF_D0L 12'h010
`define FIAP_OFF_D0H 12'h014
`define FIAP_OFF_K1L 12'h018
`define FIAP_OFF_K1H 12'h01C
`define FIAP_OFF_K2L 12'h020
`define FIAP_OFF_K2H 12'h024
`define FIAP_OFF_K3L 12'h028
`define FIAP_OFF_K3H 12'h02C
`define FIAP_OFF_STAT 12'h030
`define FIAP_B_EN 7
`define FIAP_B_MODE_HI 6
`define FIAP_B_MODE_LO 4
`define FIAP_B_TRIG 3
`define FIAP_B_WT 2
`define FIAP_B_RDEN 1
`define FIAP_B_RD 0
`define FIAP_CTRL_RST 8'h00
`define FIAP_KEY1L 8'h00
`define FIAP_KEY2L 8'h0D
`define FIAP_KEY3L 8'hC3
`define FIAP_KEY1H 8'h04
`define FIAP_KEY2H 8'h09
`define FIAP_KEY3H 8'h40
`define FIAP_CLK_HZ 25000000
`define FIAP_PROG_US 2200
`define FIAP_PROG_CYC ((`FIAP_PROG_US * (`FIAP_CLK_HZ / 1000000)))
`define FIAP_RD_CYC 3
`define FIAP_UNLOCK_CYC 1024
`endif

//--- logic/fiap_pkg.sv
// Types shared by the flash IAP sequencer files
package fiap_pkg;
  typedef enum logic [2:0] {
    FIAP_MODE_WRITE = 3'h0,
    FIAP_MODE_ERASE = 3'h1,
    FIAP_MODE_READ = 3'h3,
    FIAP_MODE_UNLOCK = 3'h6
  } fiap_mode_t;
  typedef enum logic [3:0] {
    FIAP_ST_IDLE = 4'b0001,
    FIAP_ST_ERASE = 4'b0010,
    FIAP_ST_PROG = 4'b0100,
    FIAP_ST_READ = 4'b1000
  } fiap_state_t;
endpackage

//--- logic/fiap_unlock.sv
// Timed key unlock that grants erase/write permission
`include "fiap_map.svh"
module fiap_unlock #(
  parameter int unsigned WINDOW_CYC = `FIAP_UNLOCK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_key_ok,
  output logic o_active,
  output logic o_granted
);
  import fiap_pkg::*;
  logic [15:0] cnt_reg;
  wire done = o_active && (cnt_reg == 16'h0000);
  // Window counts down; grant fires only if key matched before expiry
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= 16'h0000;
      o_active <= 1'b0;
      o_granted <= 1'b0;
    end else begin
      o_granted <= done && i_key_ok;
      if (i_start && !o_active) begin
        o_active <= 1'b1;
        cnt_reg <= 16'(WINDOW_CYC - 1);
      end else if (done) begin
        o_active <= 1'b0;
      end else if (o_active) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end
endmodule

//--- logic/fiap_timer.sv
// Operation busy timer: load a count, pulse when it runs out
module fiap_timer #(
  parameter int unsigned W = 20
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_done
);
  import fiap_pkg::*;
  logic [W-1:0] cnt_reg;
  logic run_reg;
  // Single down counter serves erase, program and read timing
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= run_reg && (cnt_reg == W'(1));
      if (i_load) begin
        cnt_reg <= i_count;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - W'(1);
        if (cnt_reg == W'(1)) begin
          run_reg <= 1'b0;
        end
      end
    end
  end
endmodule

//--- dv/fiap_seq_assertions.sv
// Port-level checker for the flash IAP sequencer
module fiap_seq_assertions #(
  parameter int unsigned PAGE_WORDS = 64,
  parameter int unsigned PROG_CYC = 100
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_cpu_stall,
  input wire logic o_fl_erase,
  input wire logic o_fl_prog,
  input wire logic o_fl_read,
  input wire logic [13:0] o_fl_addr
);
  localparam int MAXW = int'(PROG_CYC + PAGE_WORDS) + 16;
  logic [7:0] pcnt;
  logic [19:0] scnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Words handed to the array in one program run; idle clears it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) pcnt <= '0;
    else if (o_fl_prog) pcnt <= pcnt + 8'h01;
    else if (!o_cpu_stall) pcnt <= '0;
  end
  // Cycles of the current stall; a counter keeps the bound out of a long delay range
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scnt <= '0;
    end else if (o_cpu_stall) begin
      scnt <= scnt + 20'h0_0001;
    end else begin
      scnt <= '0;
    end
  end
  // Bus answer: one wait-free pulse, error only with ready
  chk_ready_setup: assert property ((i_psel && !i_penable) |=> o_pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready too long");
  chk_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  // Erase and read stall the core; erase stalls at least 8 cycles and every stall is bounded
  chk_erase_stall: assert property (o_fl_erase |-> ##[0:1] o_cpu_stall)
    else $error("erase without stall");
  chk_read_stall: assert property (o_fl_read |-> ##[0:1] o_cpu_stall)
    else $error("read without stall");
  chk_erase_long: assert property (o_fl_erase |-> ##2 o_cpu_stall [*8])
    else $error("erase ended early");
  chk_stall_bound: assert property (o_cpu_stall |-> scnt < 20'(MAXW))
    else $error("stall too long");
  chk_erase_base: assert property (o_fl_erase |-> o_fl_addr[5:0] == 6'h00)
    else $error("erase not page aligned");
  chk_prog_count: assert property ($fell(o_cpu_stall) && pcnt != 0 |-> pcnt == 8'(PAGE_WORDS))
    else $error("partial page programmed");
  cover property (o_fl_erase);
  cover property (o_fl_prog);
  cover property (o_fl_read);
  cover property (o_pslverr);
endmodule

bind fiap_seq fiap_seq_assertions #(.PAGE_WORDS(PAGE_WORDS), .PROG_CYC(PROG_CYC))
  i_fiap_seq_assertions (.i_clk, .i_rst_n, .i_psel, .i_penable, .o_pready, .o_pslverr,
  .o_cpu_stall, .o_fl_erase, .o_fl_prog, .o_fl_read, .o_fl_addr);

//--- dv/fiap_seq_test.sv
// Self-checking bench for the flash IAP sequencer
`include "fiap_map.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module fiap_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PC = 100;
  localparam int unsigned UC = 32;
  logic i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata;
  logic o_pready, o_pslverr, o_cpu_stall, o_fl_erase, o_fl_prog, o_fl_read;
  logic [13:0] o_fl_addr;
  logic [15:0] o_fl_wdata, i_fl_rdata = '0;
  logic [5:0] o_fl_widx;
  int err_count = 0, checks_done = 0, len;
  logic [32:0] rq[$];
  logic [35:0] pq[$];
  logic [15:0] w[64];
  fiap_seq #(.PROG_CYC(PC), .UNLOCK_CYC(UC)) i_fiap_seq (.i_clk, .i_rst_n, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .o_cpu_stall, .o_fl_erase, .o_fl_prog, .o_fl_read, .o_fl_addr, .o_fl_wdata,
    .o_fl_widx, .i_fl_rdata);
  always #20 i_clk = ~i_clk;
  // One APB transfer; request held until ready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= {24'h00_0000, d};
    @(posedge i_clk);
    i_penable <= 1;
    @(posedge i_clk);
    while (o_pready !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      $display("[FAIL] %0t no bus answer", $time);
    end
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic er = 0);
    rq.push_back({er, 16'h0000, e});
    apb(0, a, 8'h00);
  endtask
  // Length of the stall that follows a launch, bounded both ways
  task automatic opwait(output int l);
    int n;
    n = 0;
    l = 0;
    while (o_cpu_stall !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    while (o_cpu_stall === 1'b1 && l < 5000) begin
      @(posedge i_clk);
      l++;
    end
    if (n >= 20 || l >= 5000) begin
      err_count++;
      $display("[FAIL] %0t stall wait limit hit", $time);
    end
  endtask
  // Timed key entry; k0 spoils the first key byte when nonzero
  task automatic unlock(input logic [7:0] k0);
    logic [7:0] k[6] = '{`FIAP_KEY1L, `FIAP_KEY1H, `FIAP_KEY2L, `FIAP_KEY2H, `FIAP_KEY3L,
      `FIAP_KEY3H};
    apb(1, `FIAP_OFF_CTRL, 8'h60);
    apb(1, `FIAP_OFF_CTRL, 8'h68);
    for (int i = 0; i < 6; i++) apb(1, 12'h018 + 12'(4 * i), k[i] ^ (i == 0 ? k0 : 8'h00));
    rd(`FIAP_OFF_CTRL, 16'h0068);
    repeat (UC + 8) @(posedge i_clk);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Result watcher: oldest note against each read and program word; erase and flash read against fixed addresses
  always @(posedge i_clk) begin
    logic [32:0] e;
    logic [35:0] p;
    if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite) begin
      e = rq.pop_front();
      `CHK({o_pslverr, o_prdata}, e)
    end
    if (o_fl_prog === 1'b1) begin
      p = pq.pop_front();
      `CHK({o_fl_addr, o_fl_widx, o_fl_wdata}, p)
    end
    if (o_fl_erase === 1'b1) `CHK(o_fl_addr, 14'h0500)
    if (o_fl_read === 1'b1) `CHK(o_fl_addr, 14'h1245)
  end
  // Hang guard, far beyond the roughly one thousand cycles the run needs
  initial begin
    repeat (40000) @(posedge i_clk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    logic [15:0] rv;
    void'($urandom(32'head8aba0));
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1;
    rd(`FIAP_OFF_CTRL, 16'h0000);
    rd(`FIAP_OFF_STAT, 16'h0001);
    rd(12'h0FC, 16'h0000, 1'b1);
    apb(1, `FIAP_OFF_CTRL, 8'h80);
    rd(`FIAP_OFF_CTRL, 16'h0000);
    tend("bus");
    rv = 16'($urandom);
    i_fl_rdata <= rv;
    apb(1, `FIAP_OFF_ADDRL, 8'h45);
    apb(1, `FIAP_OFF_ADDRH, 8'h12);
    apb(1, `FIAP_OFF_CTRL, 8'h32);
    apb(1, `FIAP_OFF_CTRL, 8'h33);
    opwait(len);
    `CHK(len inside {[1:8]}, 1'b1)
    rd(`FIAP_OFF_CTRL, 16'h0032);
    rd(`FIAP_OFF_D0L, {8'h00, rv[7:0]});
    rd(`FIAP_OFF_D0H, {8'h00, rv[15:8]});
    tend("read");
    unlock(8'h01);
    rd(`FIAP_OFF_CTRL, 16'h0060);
    unlock(8'h00);
    rd(`FIAP_OFF_CTRL, 16'h00E0);
    tend("unlock");
    apb(1, `FIAP_OFF_ADDRL, 8'h3F);
    apb(1, `FIAP_OFF_ADDRH, 8'h05);
    apb(1, `FIAP_OFF_CTRL, 8'h94);
    opwait(len);
    `CHK(len inside {[PC - 2:PC + 4]}, 1'b1)
    rd(`FIAP_OFF_CTRL, 16'h0090);
    tend("erase");
    apb(1, `FIAP_OFF_CTRL, 8'h80);
    apb(1, `FIAP_OFF_ADDRL, 8'h00);
    apb(1, `FIAP_OFF_ADDRH, 8'h05);
    for (int i = 0; i < 65; i++) begin
      w[i > 63 ? 63 : i] = 16'($urandom);
      apb(1, `FIAP_OFF_D0L, w[i > 63 ? 63 : i][7:0]);
      apb(1, `FIAP_OFF_D0H, w[i > 63 ? 63 : i][15:8]);
    end
    rd(`FIAP_OFF_STAT, 16'h03F1);
    for (int i = 0; i < 64; i++) pq.push_back({8'h14, 6'(i), 6'(i), w[i]});
    apb(1, `FIAP_OFF_CTRL, 8'h84);
    opwait(len);
    rd(`FIAP_OFF_CTRL, 16'h0080);
    `CHK(pq.size(), 0)
    tend("program");
    apb(1, `FIAP_OFF_BCLR, 8'h01);
    repeat (70) @(posedge i_clk);
    rd(`FIAP_OFF_BCLR, 16'h0000);
    apb(1, `FIAP_OFF_ADDRL, 8'h02);
    apb(1, `FIAP_OFF_D0L, 8'hA5);
    apb(1, `FIAP_OFF_D0H, 8'h5A);
    rd(`FIAP_OFF_STAT, 16'h0031);
    for (int i = 0; i < 64; i++) begin
      pq.push_back({8'h14, 6'(i), 6'(i), (i == 2 ? 16'h5AA5 : 16'h0000)});
    end
    apb(1, `FIAP_OFF_CTRL, 8'h84);
    opwait(len);
    rd(`FIAP_OFF_CTRL, 16'h0080);
    `CHK(pq.size(), 0)
    apb(1, `FIAP_OFF_CTRL, 8'h00);
    rd(`FIAP_OFF_CTRL, 16'h0000);
    tend("rewrite");
    i_rst_n <= 0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1;
    rd(`FIAP_OFF_STAT, 16'h0001);
    tend("reset");
    repeat (4) @(posedge i_clk);
    tally_and_finish;
  end
endmodule
